// >>> hw/caoc_defines.svh
// Purpose: Offsets, field positions and reset values of the counter array output control.
// Assumes: 8-bit special-function register bus.
// Notes: Definitions only.
`ifndef CAOC_DEFINES_SVH
`define CAOC_DEFINES_SVH

// Register offsets
`define CAOC_OFS_POLARITY 8'h96
`define CAOC_OFS_CENTER 8'h9e
`define CAOC_OFS_MODE1 8'hdb
`define CAOC_OFS_MODE0 8'hda
`define CAOC_OFS_PWM_CTL 8'hdf
`define CAOC_OFS_CMP0_LOW 8'hfb
`define CAOC_OFS_CMP0_HIGH 8'hfc

// Field positions
`define CAOC_BIT_AUTO_RELOAD_SEL 7
`define CAOC_CHAN_MSB 2

// Reset values
`define CAOC_RST_BYTE 8'h00
`define CAOC_RST_CHAN 3'h0

`endif

// >>> hw/caoc_pkg.sv
// Purpose: Types shared by the counter array output control.
// Assumes: Constants live in caoc_defines.svh.
// Notes: Mode byte fields run from bit 7 down to bit 0.
package caoc_pkg;

  // One channel mode byte, bit 7 first
  typedef struct packed {
    logic sixteen_bit_pwm_select;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_enable;
    logic toggle_enable;
    logic pwm_enable;
    logic flag_interrupt_enable;
  } caoc_mode_t;

  // One bus access; rd and wr never both high
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } caoc_sfr_req_t;

  // Decoded channel function
  typedef enum logic [2:0] {
    CAOC_FUNC_IDLE = 3'b000,
    CAOC_FUNC_CAPTURE = 3'b001,
    CAOC_FUNC_MATCH = 3'b010,
    CAOC_FUNC_TOGGLE = 3'b011,
    CAOC_FUNC_PWM_NARROW = 3'b100,
    CAOC_FUNC_PWM_WIDE = 3'b101,
    CAOC_FUNC_FREQ_OUT = 3'b110
  } caoc_func_t;

endpackage : caoc_pkg

// >>> hw/caoc_top.sv
// Purpose: Register slice of a three-channel counter array: compare bytes, polarity,
//          alignment and channel mode registers, with the output pin stage.
// Assumes: Bus inputs synchronous to clk_in; one access per cycle.
// Notes: Read data appears one cycle after the read strobe.
`include "caoc_defines.svh"

// Functional notes
// RULE1 - Channel 0 compare high byte holds bits 15:8 of the compare value.
// RULE2 - Same address reaches the auto-reload high byte for 9 to 11-bit PWM.
// RULE3 - Auto-reload select bit steers that address to compare or reload byte.
// RULE4 - Writing channel 0 compare high sets its comparator enable.
// RULE5 - Polarity bits 2..0 per channel; 1 inverts the channel output.
// RULE6 - Polarity change reaches the pin at once, no period wait.
// RULE7 - Software writes zero into bits 7:3 of polarity and alignment.
// RULE8 - Alignment bits 2..0 per channel; 0 edge, 1 center aligned.
// RULE9 - Alignment acts only in PWM modes, never in other modes.
// RULE10 - Channel 1 mode byte at 0xdb, eight read/write fields, reset zero.
// RULE11 - Writing channel 0 compare low clears its comparator enable.
// RULE12 - Sixteen-bit select 0 gives 8 to 11-bit PWM, 1 gives 16-bit.
// RULE13 - Toggle plus PWM enable gives frequency output instead of PWM.
// RULE14 - Reserved bits 7:3 of polarity and alignment read zero.
module caoc_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire caoc_pkg::caoc_sfr_req_t sfr_req_in,
  input wire logic [2:0] chan_wave_in,
  input wire logic chan2_pwm_in,
  output logic [7:0] sfr_rdata_out,
  output logic [2:0] chan_pin_out,
  output logic [15:0] chan0_compare_out,
  output logic [15:0] chan0_reload_out,
  output caoc_pkg::caoc_mode_t chan0_mode_out,
  output caoc_pkg::caoc_mode_t chan1_mode_out,
  output caoc_pkg::caoc_func_t chan0_func_out,
  output caoc_pkg::caoc_func_t chan1_func_out,
  output logic [2:0] chan_center_out
);
  import caoc_pkg::*;

  logic [2:0] polarity;
  logic [2:0] center;
  logic auto_reload_select;
  logic [7:0] cmp_low;
  logic [7:0] cmp_high;
  logic [7:0] rld_low;
  logic [7:0] rld_high;
  logic [2:0] pwm_active;
  logic wr_pol;
  logic wr_cent;
  logic wr_mode0;
  logic wr_mode1;
  logic wr_pwm_ctl;
  logic wr_low;
  logic wr_high;
  logic [7:0] next_rdata;

  // Write strobes per register
  assign wr_pol = sfr_req_in.wr && (sfr_req_in.addr == `CAOC_OFS_POLARITY);
  assign wr_cent = sfr_req_in.wr && (sfr_req_in.addr == `CAOC_OFS_CENTER);
  assign wr_mode0 = sfr_req_in.wr && (sfr_req_in.addr == `CAOC_OFS_MODE0);
  assign wr_mode1 = sfr_req_in.wr && (sfr_req_in.addr == `CAOC_OFS_MODE1);
  assign wr_pwm_ctl = sfr_req_in.wr && (sfr_req_in.addr == `CAOC_OFS_PWM_CTL);
  assign wr_low = sfr_req_in.wr && (sfr_req_in.addr == `CAOC_OFS_CMP0_LOW);
  assign wr_high = sfr_req_in.wr && (sfr_req_in.addr == `CAOC_OFS_CMP0_HIGH);

  // Decode a mode byte; frequency output outranks plain PWM
  function automatic caoc_func_t decode_func(input caoc_mode_t m);
    caoc_func_t f;
    f = CAOC_FUNC_IDLE;
    if (m.pwm_enable && m.toggle_enable) begin
      f = CAOC_FUNC_FREQ_OUT; // [RULE13]
    end else if (m.pwm_enable) begin
      f = m.sixteen_bit_pwm_select ? CAOC_FUNC_PWM_WIDE : CAOC_FUNC_PWM_NARROW; // [RULE12]
    end else if (m.toggle_enable) begin
      f = CAOC_FUNC_TOGGLE;
    end else if (m.match_enable) begin
      f = CAOC_FUNC_MATCH;
    end else if (m.rising_capture_enable || m.falling_capture_enable) begin
      f = CAOC_FUNC_CAPTURE;
    end
    return f;
  endfunction : decode_func

  // Polarity and alignment; only the low three bits are stored
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      polarity <= `CAOC_RST_CHAN;
      center <= `CAOC_RST_CHAN;
    end else begin
      if (wr_pol) begin
        polarity <= sfr_req_in.wdata[`CAOC_CHAN_MSB:0]; // [RULE5] [RULE14]
      end
      if (wr_cent) begin
        center <= sfr_req_in.wdata[`CAOC_CHAN_MSB:0]; // [RULE8] [RULE14]
      end
    end
  end

  // Auto-reload select in the PWM control register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      auto_reload_select <= 1'b0;
    end else if (wr_pwm_ctl) begin
      auto_reload_select <= sfr_req_in.wdata[`CAOC_BIT_AUTO_RELOAD_SEL];
    end
  end

  // Compare and reload bytes share addresses, steered by the select bit
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_low <= `CAOC_RST_BYTE;
      cmp_high <= `CAOC_RST_BYTE;
      rld_low <= `CAOC_RST_BYTE;
      rld_high <= `CAOC_RST_BYTE;
    end else begin
      if (wr_low && !auto_reload_select) begin
        cmp_low <= sfr_req_in.wdata;
      end
      if (wr_low && auto_reload_select) begin
        rld_low <= sfr_req_in.wdata;
      end
      if (wr_high && !auto_reload_select) begin
        cmp_high <= sfr_req_in.wdata; // [RULE1] [RULE3]
      end
      if (wr_high && auto_reload_select) begin
        rld_high <= sfr_req_in.wdata; // [RULE2] [RULE3]
      end
    end
  end

  // Channel 0 mode; compare byte writes override the enable whatever the select
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chan0_mode_out <= caoc_mode_t'(`CAOC_RST_BYTE);
    end else if (wr_mode0) begin
      chan0_mode_out <= caoc_mode_t'(sfr_req_in.wdata);
    end else if (wr_high) begin
      chan0_mode_out.comparator_enable <= 1'b1; // [RULE4]
    end else if (wr_low) begin
      chan0_mode_out.comparator_enable <= 1'b0; // [RULE11]
    end
  end

  // Channel 1 mode byte, all fields plain read/write
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chan1_mode_out <= caoc_mode_t'(`CAOC_RST_BYTE);
    end else if (wr_mode1) begin
      chan1_mode_out <= caoc_mode_t'(sfr_req_in.wdata); // [RULE10]
    end
  end

  // Read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    next_rdata = `CAOC_RST_BYTE;
    case (sfr_req_in.addr)
      `CAOC_OFS_POLARITY: next_rdata = {5'h00, polarity}; // [RULE14]
      `CAOC_OFS_CENTER: next_rdata = {5'h00, center}; // [RULE14]
      `CAOC_OFS_MODE0: next_rdata = chan0_mode_out;
      `CAOC_OFS_MODE1: next_rdata = chan1_mode_out; // [RULE10]
      `CAOC_OFS_PWM_CTL: next_rdata = {auto_reload_select, 7'h00};
      `CAOC_OFS_CMP0_LOW: next_rdata = auto_reload_select ? rld_low : cmp_low;
      `CAOC_OFS_CMP0_HIGH: next_rdata = auto_reload_select ? rld_high : cmp_high; // [RULE3]
      default: next_rdata = `CAOC_RST_BYTE;
    endcase
  end

  // Read data register, updated only on a read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sfr_rdata_out <= `CAOC_RST_BYTE;
    end else if (sfr_req_in.rd) begin
      sfr_rdata_out <= next_rdata;
    end
  end

  // Wide values and decoded functions, registered for clean outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chan0_compare_out <= 16'h0000;
      chan0_reload_out <= 16'h0000;
      chan0_func_out <= CAOC_FUNC_IDLE;
      chan1_func_out <= CAOC_FUNC_IDLE;
    end else begin
      chan0_compare_out <= {cmp_high, cmp_low}; // [RULE1]
      chan0_reload_out <= {rld_high, rld_low}; // [RULE2]
      chan0_func_out <= decode_func(chan0_mode_out); // [RULE12] [RULE13]
      chan1_func_out <= decode_func(chan1_mode_out);
    end
  end

  // Channel 2 mode lives outside; its PWM state arrives as a level.
  // Toggle plus PWM is frequency output, not PWM, so alignment stays off there
  assign pwm_active = {chan2_pwm_in,
    chan1_mode_out.pwm_enable && !chan1_mode_out.toggle_enable,
    chan0_mode_out.pwm_enable && !chan0_mode_out.toggle_enable}; // [RULE9] [RULE13]

  // Per-channel pin stage; polarity is applied after the waveform so a change
  // shows on the next edge instead of waiting for a period boundary
  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        chan_pin_out[ch] <= 1'b0;
        chan_center_out[ch] <= 1'b0;
      end else begin
        chan_pin_out[ch] <= chan_wave_in[ch] ^ polarity[ch]; // [RULE5] [RULE6]
        chan_center_out[ch] <= center[ch] && pwm_active[ch]; // [RULE8] [RULE9]
      end
    end
  end

  // Checks on the register behaviour

  a_high_sets_enable: assert property ( // [RULE4]
    @(posedge clk_in) disable iff (rst_in)
    wr_high |=> chan0_mode_out.comparator_enable)
    else $error("Compare high write did not set the comparator enable");

  a_low_clears_enable: assert property ( // [RULE11]
    @(posedge clk_in) disable iff (rst_in)
    wr_low |=> !chan0_mode_out.comparator_enable)
    else $error("Compare low write did not clear the comparator enable");

  a_high_to_compare: assert property ( // [RULE1]
    @(posedge clk_in) disable iff (rst_in)
    (wr_high && !auto_reload_select) |=> ##1
      (chan0_compare_out[15:8] == $past(sfr_req_in.wdata, 2)))
    else $error("Compare high byte not in bits 15:8");

  a_high_to_reload: assert property ( // [RULE2]
    @(posedge clk_in) disable iff (rst_in)
    (wr_high && auto_reload_select) |=> ##1
      (chan0_reload_out[15:8] == $past(sfr_req_in.wdata, 2)))
    else $error("Reload high byte not updated through shared address");

  a_select_guards_cmp: assert property ( // [RULE3]
    @(posedge clk_in) disable iff (rst_in)
    (wr_high && auto_reload_select) |=> $stable(cmp_high))
    else $error("Compare byte changed while reload was selected");

  a_polarity_readback: assert property ( // [RULE14]
    @(posedge clk_in) disable iff (rst_in)
    (sfr_req_in.rd && sfr_req_in.addr == `CAOC_OFS_POLARITY) |=>
      (sfr_rdata_out[7:3] == 5'h00) && (sfr_rdata_out[2:0] == $past(polarity)))
    else $error("Polarity read showed reserved bits or wrong value");

  a_center_readback: assert property ( // [RULE14]
    @(posedge clk_in) disable iff (rst_in)
    (sfr_req_in.rd && sfr_req_in.addr == `CAOC_OFS_CENTER) |=>
      (sfr_rdata_out[7:3] == 5'h00) && (sfr_rdata_out[2:0] == $past(center)))
    else $error("Alignment read showed reserved bits or wrong value");

  a_pin_inverts_now: assert property ( // [RULE6]
    @(posedge clk_in) disable iff (rst_in)
    wr_pol |=> ##1 (chan_pin_out == ($past(chan_wave_in) ^ $past(sfr_req_in.wdata[2:0], 2))))
    else $error("Polarity change did not reach the pins within two cycles");

  a_center_pwm_only: assert property ( // [RULE9]
    @(posedge clk_in) disable iff (rst_in)
    (!chan0_mode_out.pwm_enable || chan0_mode_out.toggle_enable) |=>
      !chan_center_out[0])
    else $error("Center alignment active outside PWM mode");

  a_freq_no_center: assert property ( // [RULE9]
    @(posedge clk_in) disable iff (rst_in)
    (chan1_mode_out.pwm_enable && chan1_mode_out.toggle_enable) |=> !chan_center_out[1])
    else $error("Center alignment active in frequency output mode");

  a_center_follows: assert property ( // [RULE8]
    @(posedge clk_in) disable iff (rst_in)
    (center[1] && chan1_mode_out.pwm_enable) |=>
      (chan_center_out[1] == !$past(chan1_mode_out.toggle_enable)))
    else $error("Center alignment not applied in PWM mode");

  a_mode1_write_read: assert property ( // [RULE10]
    @(posedge clk_in) disable iff (rst_in)
    wr_mode1 ##1 (sfr_req_in.rd && sfr_req_in.addr == `CAOC_OFS_MODE1) |=>
      (sfr_rdata_out == $past(sfr_req_in.wdata, 2)))
    else $error("Channel 1 mode byte did not read back");

  a_mode1_no_stray: assert property ( // [RULE10]
    @(posedge clk_in) disable iff (rst_in)
    !wr_mode1 |=> $stable(chan1_mode_out))
    else $error("Channel 1 mode byte changed without a write");

  a_rdata_holds: assert property ( // [RULE10]
    @(posedge clk_in) disable iff (rst_in)
    !sfr_req_in.rd |=> $stable(sfr_rdata_out))
    else $error("Read data changed without a read");

  a_freq_output: assert property ( // [RULE13]
    @(posedge clk_in) disable iff (rst_in)
    (chan1_mode_out.pwm_enable && chan1_mode_out.toggle_enable) |=>
      (chan1_func_out == CAOC_FUNC_FREQ_OUT))
    else $error("Toggle with PWM did not select frequency output");

  a_pwm_width_select: assert property ( // [RULE12]
    @(posedge clk_in) disable iff (rst_in)
    (chan1_mode_out.pwm_enable && !chan1_mode_out.toggle_enable) |=>
      (chan1_func_out == ($past(chan1_mode_out.sixteen_bit_pwm_select) ?
        CAOC_FUNC_PWM_WIDE : CAOC_FUNC_PWM_NARROW)))
    else $error("Sixteen-bit select chose the wrong PWM width");

  a_invert_bit: assert property ( // [RULE5]
    @(posedge clk_in) disable iff (rst_in)
    (polarity[2] && chan_wave_in[2]) |=> !chan_pin_out[2])
    else $error("Channel 2 output not inverted");

endmodule : caoc_top

// >>> test/caoc_bench.sv
// Purpose: Self-checking bench for the counter array output control register slice.
// Assumes: One bus access per request, read data one cycle after the strobe.
// Notes: Each access task call leaves one idle cycle; the mode 1 back-to-back check drives write then read with no gap.
module counter_array_output_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import caoc_pkg::*;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  caoc_sfr_req_t sfr_req = '0;
  logic [2:0] chan_wave = 3'h0;
  logic chan2_pwm = 1'b0;
  logic [7:0] rdata;
  logic [2:0] pins;
  logic [15:0] cmp0;
  logic [15:0] rld0;
  caoc_mode_t mode0;
  caoc_mode_t mode1;
  caoc_func_t func0;
  caoc_func_t func1;
  logic [2:0] center;
  integer error_cnt = 0;
  integer n_tests = 0;
  integer seed = 15853;
  integer cycles = 0;
  logic [7:0] v;
  logic [7:0] w;
  logic [2:0] ex;
  logic [7:0] md [0:7] = '{8'h00, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h82, 8'h06};

  caoc_top DUT (
    .clk_in(clk_in), .rst_in(rst_in), .sfr_req_in(sfr_req), .chan_wave_in(chan_wave),
    .chan2_pwm_in(chan2_pwm), .sfr_rdata_out(rdata), .chan_pin_out(pins),
    .chan0_compare_out(cmp0), .chan0_reload_out(rld0), .chan0_mode_out(mode0),
    .chan1_mode_out(mode1), .chan0_func_out(func0), .chan1_func_out(func1),
    .chan_center_out(center)
  );

  // Free-running 125 MHz clock
  initial begin
    forever #4 clk_in = ~clk_in;
  end

  // Cycle ceiling; the whole run needs a few hundred cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end

  // Expected function decode, priority as handed over
  function automatic caoc_func_t exp_func(input caoc_mode_t m);
    if (m.pwm_enable && m.toggle_enable) return CAOC_FUNC_FREQ_OUT;
    if (m.pwm_enable) return m.sixteen_bit_pwm_select ? CAOC_FUNC_PWM_WIDE : CAOC_FUNC_PWM_NARROW;
    if (m.toggle_enable) return CAOC_FUNC_TOGGLE;
    if (m.match_enable) return CAOC_FUNC_MATCH;
    if (m.rising_capture_enable || m.falling_capture_enable) return CAOC_FUNC_CAPTURE;
    return CAOC_FUNC_IDLE;
  endfunction : exp_func

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_cyc(input integer n);
    repeat (n) @(negedge clk_in);
  endtask : wait_cyc

  // One strobe cycle, then the bus goes idle on the next falling edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    sfr_req = '{wr: wr, rd: ~wr, addr: a, wdata: d};
    @(negedge clk_in);
    sfr_req = '0;
  endtask : access

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask : wr_reg

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    access(1'b0, a, 8'h00);
    check(what, {8'h00, exp}, {8'h00, rdata});
  endtask : rd_chk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    wait_cyc(5);
    rst_in = 1'b0;
    // Reset values, unmapped address included
    rd_chk("polarity rst", 8'h96, 8'h00);
    rd_chk("center rst", 8'h9e, 8'h00);
    rd_chk("mode1 rst", 8'hdb, 8'h00);
    rd_chk("cmp high rst", 8'hfc, 8'h00);
    rd_chk("unmapped", 8'h55, 8'h00);
    $display("test reset values done");
    // Polarity; software keeps reserved bits zero, the first pass writes junk there
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      chan_wave = $random(seed);
      wr_reg(8'h96, (i == 0) ? v : {5'h00, v[2:0]});
      wait_cyc(1);
      check("pins after write", {13'h0, chan_wave ^ v[2:0]}, {13'h0, pins});
      chan_wave = $random(seed);
      wait_cyc(1);
      check("pins", {13'h0, chan_wave ^ v[2:0]}, {13'h0, pins});
      rd_chk("polarity rd", 8'h96, {5'h00, v[2:0]});
    end
    $display("test polarity done");
    // Channel 1 mode: every function code, then random bytes
    for (int i = 0; i < 24; i++) begin
      v = (i < 8) ? md[i] : 8'($random(seed));
      wr_reg(8'hdb, v);
      wait_cyc(1);
      check("mode1 out", {8'h00, v}, {8'h00, mode1});
      check("func1", {13'h0, exp_func(v)}, {13'h0, func1});
      rd_chk("mode1 rd", 8'hdb, v);
    end
    // Write then read in the very next cycle, back to back
    @(negedge clk_in);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: 8'hdb, wdata: 8'h5a};
    @(negedge clk_in);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: 8'hdb, wdata: 8'h00};
    @(negedge clk_in);
    sfr_req = '0;
    check("mode1 back to back", 16'h005a, {8'h00, rdata});
    $display("test mode decode done");
    // Alignment applies only to channels in a PWM mode
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      w = $random(seed);
      chan2_pwm = w[2];
      wr_reg(8'hda, {5'h00, w[3], w[0], 1'b0});
      wr_reg(8'hdb, {5'h00, w[4], w[1], 1'b0});
      wr_reg(8'h9e, (i == 0) ? v : {5'h00, v[2:0]});
      wait_cyc(1);
      // Frequency output (toggle with PWM) is not a PWM mode
      ex = v[2:0] & {w[2], w[1] & ~w[4], w[0] & ~w[3]};
      check("center", {13'h0, ex}, {13'h0, center});
      check("func0", {13'h0, exp_func({5'h00, w[3], w[0], 1'b0})}, {13'h0, func0});
      rd_chk("center rd", 8'h9e, {5'h00, v[2:0]});
    end
    $display("test alignment done");
    // Shared compare/reload address and comparator enable side effects
    v = $random(seed);
    w = $random(seed);
    wr_reg(8'hda, 8'h40);
    wr_reg(8'hdf, 8'h00);
    wr_reg(8'hfb, v);
    wait_cyc(1);
    check("cmp enable cleared", 16'h0000, {15'h0, mode0.comparator_enable});
    wr_reg(8'hfc, w);
    wait_cyc(1);
    check("cmp enable set", 16'h0001, {15'h0, mode0.comparator_enable});
    check("compare", {w, v}, cmp0);
    wr_reg(8'hdf, 8'h80);
    wr_reg(8'hfc, ~w);
    wr_reg(8'hfb, ~v);
    wait_cyc(1);
    check("reload", {~w, ~v}, rld0);
    check("compare kept", {w, v}, cmp0);
    rd_chk("reload rd", 8'hfc, ~w);
    wr_reg(8'hdf, 8'h00);
    rd_chk("cmp high rd", 8'hfc, w);
    $display("test shared address done");
    // Second reset in mid-run clears everything
    @(negedge clk_in);
    rst_in = 1'b1;
    wait_cyc(2);
    check("mode1 in rst", 16'h0000, {8'h00, mode1});
    check("compare in rst", 16'h0000, cmp0);
    rst_in = 1'b0;
    rd_chk("polarity rst2", 8'h96, 8'h00);
    $display("test second reset done");
    conclude();
  end
endmodule : counter_array_output_control_bench
